// File: core/slbs_serial_port.sv
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps

// Behaviour
// [R1] while wake enabled, normal reception stops; a falling data line is the wake event
// [R2] wake event sets receive flag; next rising data line clears wake enable
// [R3] reading receive data clears the wake-induced flag; software discards the value
// [R4] software checks receiver idle before enabling wake prior to sleep
// [R5] break character: start bit, twelve low bits, stop bit
// [R6] with send-break and transmit enable set, a data write starts the break
// [R7] during a break the written value is ignored and zeros are sent
// [R8] send-break clears after the break stop bit; the preloaded byte goes next
// [R9] shift-empty status reports break activity like normal characters
// [R10] lin master: send-break, dummy write, then sync byte write
// [R11] transmit flag set when the holding register empties
// [R12] received break shows receive flag, framing error and zero data
// [R13] with wake enabled: two transitions, an interrupt, then next byte and interrupt
// [R14] auto-baud enable accepted together with either break detection method
// [R15] sync mode: shared data line plus clock, half duplex, no start or stop
// [R16] sync, master, port enable and no receive enable select master transmit
// [R17] sync master drives and enables the clock pin for transmit and receive
// [R18] one clock per data bit, no extra clocks
// [R19] data changes on leading clock edge and holds until the next
// [R20] clock polarity set: idle high, change on falling; clear: all inverted
// [R21] sync master transmit drives data on the data pin, both drivers enabled
// [R22] a write waits in holding while the shift register is busy, else loads
// [R23] data polarity resets to zero (active high); set inverts tx and rx data
// [R24] characters shift out least significant bit first
module slbs_serial_port (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // receive_data_pin
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe,
    // transmit_clock_pin
    input wire logic clk_pin_in,
    output logic clk_pin_out,
    output logic clk_pin_oe
);

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // ****************************************
    // register port
    // ****************************************
    slbs_pkg::slbs_ctrl_t ctrl_reg;
    slbs_pkg::slbs_status_t status;
    logic [15:0] baud_reg;
    logic [7:0] hold_reg;
    logic hold_valid_reg;
    logic [7:0] rx_data_reg;
    logic rx_flag_reg;
    logic framing_error_flag_reg;
    logic [15:0] reg_rdata_reg;
    logic wr_ctrl, wr_tx, rd_rx;
    logic break_done, load, rx_done, wake_evt, wake_end;

    assign wr_ctrl = reg_write && reg_addr == slbs_pkg::ADDR_CTRL;
    assign wr_tx = reg_write && reg_addr == slbs_pkg::ADDR_TXDATA;
    assign rd_rx = reg_read && reg_addr == slbs_pkg::ADDR_RXDATA;

    // control: software write, hardware clears of send-break and wake enable
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_reg <= slbs_pkg::CTRL_RESET; // see [R23]
        end else if (wr_ctrl) begin
            ctrl_reg <= slbs_pkg::slbs_ctrl_t'(reg_wdata[slbs_pkg::CTRL_W-1:0]); // see [R14]
        end else begin
            if (break_done) begin
                ctrl_reg.send_break_request <= 1'b0; // see [R8]
            end
            if (wake_end) begin
                ctrl_reg.wake_on_break_enable <= 1'b0; // see [R2]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            baud_reg <= slbs_pkg::BAUD_RESET;
        end else if (reg_write && reg_addr == slbs_pkg::ADDR_BAUD) begin
            baud_reg <= (reg_wdata < 16'h0002) ? 16'h0002 : reg_wdata;
        end
    end

    // holding register; a new write wins over the transfer
    always_ff @(posedge clock) begin
        if (reset) begin
            hold_reg <= 8'h00;
            hold_valid_reg <= 1'b0;
        end else if (wr_tx) begin
            hold_reg <= reg_wdata[7:0]; // see [R22]
            hold_valid_reg <= 1'b1;
        end else if (load) begin
            hold_valid_reg <= 1'b0; // see [R11]
        end
    end

    // receive flag: event set wins over the read clear
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_flag_reg <= 1'b0;
        end else if (rx_done || wake_evt) begin
            rx_flag_reg <= 1'b1; // see [R2]
        end else if (rd_rx) begin
            rx_flag_reg <= 1'b0; // see [R3]
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata_reg <= 16'h0000;
        end else if (reg_read) begin
            unique case (reg_addr)
                slbs_pkg::ADDR_CTRL: reg_rdata_reg <= {5'h00, ctrl_reg};
                slbs_pkg::ADDR_RXDATA: reg_rdata_reg <= {8'h00, rx_data_reg};
                slbs_pkg::ADDR_STATUS: reg_rdata_reg <= {11'h000, status};
                slbs_pkg::ADDR_BAUD: reg_rdata_reg <= baud_reg;
                default: reg_rdata_reg <= 16'h0000;
            endcase
        end else begin
            reg_rdata_reg <= 16'h0000;
        end
    end
    assign reg_rdata = reg_rdata_reg;

    // ****************************************
    // mode decode
    // ****************************************
    logic sync_master, sync_rx_sel, tx_mode_ok;
    assign sync_master = ctrl_reg.serial_port_enable && ctrl_reg.sync_mode
                         && ctrl_reg.master_clock_source_select;
    assign sync_rx_sel = ctrl_reg.single_receive_enable || ctrl_reg.continuous_receive_enable;
    // sync master transmits only with both receive enables clear
    assign tx_mode_ok = ctrl_reg.serial_port_enable && ctrl_reg.transmit_enable
                        && (!ctrl_reg.sync_mode || (sync_master && !sync_rx_sel)); // see [R16]

    // ****************************************
    // transmitter
    // ****************************************
    logic [13:0] tx_shift_reg;
    logic [3:0] tx_left_reg;
    logic [15:0] tx_cnt_reg;
    logic tx_busy_reg, tx_break_reg, tx_sync_reg;
    logic bit_end, tx_bit;

    assign bit_end = tx_busy_reg && tx_cnt_reg == baud_reg - 16'h0001;
    assign load = !tx_busy_reg && hold_valid_reg && tx_mode_ok; // see [R22]
    assign break_done = bit_end && tx_left_reg == 4'h1 && tx_break_reg;
    assign tx_bit = tx_busy_reg ? tx_shift_reg[0] : 1'b1;

    always_ff @(posedge clock) begin
        if (reset) begin
            tx_shift_reg <= 14'h0000;
            tx_left_reg <= 4'h0;
            tx_cnt_reg <= 16'h0000;
            tx_busy_reg <= 1'b0;
            tx_break_reg <= 1'b0;
            tx_sync_reg <= 1'b0;
        end else if (load) begin
            tx_busy_reg <= 1'b1;
            tx_cnt_reg <= 16'h0000;
            tx_sync_reg <= ctrl_reg.sync_mode;
            tx_break_reg <= 1'b0;
            if (ctrl_reg.sync_mode) begin
                tx_shift_reg <= {6'h00, hold_reg}; // see [R15]
                tx_left_reg <= slbs_pkg::DATA_BITS; // see [R18]
            end else if (ctrl_reg.send_break_request) begin
                tx_shift_reg <= {1'b1, 12'h000, 1'b0}; // see [R5] see [R7] see [R6]
                tx_left_reg <= slbs_pkg::BREAK_FRAME_BITS;
                tx_break_reg <= 1'b1;
            end else begin
                tx_shift_reg <= {4'h0, 1'b1, hold_reg, 1'b0};
                tx_left_reg <= slbs_pkg::ASYNC_FRAME_BITS;
            end
        end else if (tx_busy_reg && !tx_mode_ok) begin
            tx_busy_reg <= 1'b0;
            tx_break_reg <= 1'b0;
        end else if (bit_end) begin
            tx_cnt_reg <= 16'h0000;
            tx_shift_reg <= {1'b0, tx_shift_reg[13:1]}; // see [R24]
            tx_left_reg <= tx_left_reg - 4'h1;
            if (tx_left_reg == 4'h1) begin
                tx_busy_reg <= 1'b0;
                tx_break_reg <= 1'b0;
            end
        end else if (tx_busy_reg) begin
            tx_cnt_reg <= tx_cnt_reg + 16'h0001;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    logic sck_active;
    // clock active in the first half of each bit: leading edge at bit start
    assign sck_active = tx_busy_reg && tx_sync_reg && tx_cnt_reg < {1'b0, baud_reg[15:1]};

    slbs_pkg::slbs_pin_t data_pin_reg, clk_pin_reg;
    always_ff @(posedge clock) begin
        if (reset) begin
            data_pin_reg <= '0;
            clk_pin_reg <= '0;
        end else if (sync_master) begin
            data_pin_reg.out <= tx_bit ^ ctrl_reg.data_polarity_select; // see [R19] see [R23]
            data_pin_reg.oe <= !sync_rx_sel; // see [R21]
            clk_pin_reg.out <= ctrl_reg.clock_polarity_select ^ sck_active; // see [R20] see [R18]
            clk_pin_reg.oe <= 1'b1; // see [R17]
        end else begin
            data_pin_reg <= '0;
            clk_pin_reg.out <= tx_bit ^ ctrl_reg.data_polarity_select;
            clk_pin_reg.oe <= ctrl_reg.serial_port_enable && !ctrl_reg.sync_mode
                              && ctrl_reg.transmit_enable;
        end
    end
    assign data_pin_out = data_pin_reg.out;
    assign data_pin_oe = data_pin_reg.oe;
    assign clk_pin_out = clk_pin_reg.out;
    assign clk_pin_oe = clk_pin_reg.oe;

    // ****************************************
    // receive line synchroniser and edges
    // ****************************************
    logic rx_meta_reg, rx_sync_reg, rx_prev_reg, rx_now, rx_fall, rx_rise;
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= data_pin_in;
            rx_sync_reg <= rx_meta_reg;
        end
    end
    assign rx_now = rx_sync_reg ^ ctrl_reg.data_polarity_select; // see [R23]

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_prev_reg <= 1'b1;
        end else begin
            rx_prev_reg <= rx_now;
        end
    end
    assign rx_fall = rx_prev_reg && !rx_now;
    assign rx_rise = !rx_prev_reg && rx_now;

    // ****************************************
    // wake on break
    // ****************************************
    logic wake_armed;
    assign wake_armed = ctrl_reg.serial_port_enable && !ctrl_reg.sync_mode
                        && ctrl_reg.wake_on_break_enable;
    assign wake_evt = wake_armed && rx_fall; // see [R1] see [R13]
    assign wake_end = wake_armed && rx_rise; // see [R2]

    // ****************************************
    // asynchronous receiver
    // ****************************************
    slbs_pkg::slbs_rx_state_t rx_state_reg;
    logic [15:0] rx_cnt_reg;
    logic [2:0] rx_bits_reg;
    logic [7:0] rx_shift_reg;
    logic rx_en, rx_bit_end;

    // wake enable holds the receiver idle
    assign rx_en = ctrl_reg.serial_port_enable && !ctrl_reg.sync_mode
                   && ctrl_reg.continuous_receive_enable && !ctrl_reg.wake_on_break_enable; // see [R1]
    assign rx_bit_end = rx_cnt_reg == baud_reg - 16'h0001;
    assign rx_done = rx_state_reg == slbs_pkg::RX_STOP && rx_bit_end;

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_state_reg <= slbs_pkg::RX_IDLE;
            rx_cnt_reg <= 16'h0000;
            rx_bits_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
        end else if (!rx_en) begin
            rx_state_reg <= slbs_pkg::RX_IDLE;
            rx_cnt_reg <= 16'h0000;
        end else begin
            unique case (rx_state_reg)
                slbs_pkg::RX_IDLE: begin
                    rx_cnt_reg <= 16'h0000;
                    if (rx_fall) begin
                        rx_state_reg <= slbs_pkg::RX_START;
                    end
                end
                slbs_pkg::RX_START: begin
                    if (rx_cnt_reg == {1'b0, baud_reg[15:1]}) begin
                        rx_cnt_reg <= 16'h0000;
                        rx_bits_reg <= 3'h0;
                        rx_state_reg <= rx_now ? slbs_pkg::RX_IDLE : slbs_pkg::RX_DATA;
                    end else begin
                        rx_cnt_reg <= rx_cnt_reg + 16'h0001;
                    end
                end
                slbs_pkg::RX_DATA: begin
                    if (rx_bit_end) begin
                        rx_cnt_reg <= 16'h0000;
                        rx_shift_reg <= {rx_now, rx_shift_reg[7:1]};
                        rx_bits_reg <= rx_bits_reg + 3'h1;
                        if (rx_bits_reg == 3'h7) begin
                            rx_state_reg <= slbs_pkg::RX_STOP;
                        end
                    end else begin
                        rx_cnt_reg <= rx_cnt_reg + 16'h0001;
                    end
                end
                slbs_pkg::RX_STOP: begin
                    if (rx_bit_end) begin
                        rx_cnt_reg <= 16'h0000;
                        rx_state_reg <= rx_now ? slbs_pkg::RX_IDLE : slbs_pkg::RX_HOLD;
                    end else begin
                        rx_cnt_reg <= rx_cnt_reg + 16'h0001;
                    end
                end
                slbs_pkg::RX_HOLD: begin
                    // a break keeps the line low; wait for it to rise
                    if (rx_now) begin
                        rx_state_reg <= slbs_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_data_reg <= 8'h00;
            framing_error_flag_reg <= 1'b0;
        end else if (rx_done) begin
            rx_data_reg <= rx_shift_reg; // see [R12]
            framing_error_flag_reg <= !rx_now;
        end
    end

    assign status.shift_register_empty_status = !tx_busy_reg; // see [R9]
    assign status.transmit_interrupt_flag = !hold_valid_reg; // see [R11]
    assign status.receive_interrupt_flag = rx_flag_reg;
    assign status.framing_error_flag = framing_error_flag_reg;
    assign status.receiver_idle_status = rx_state_reg == slbs_pkg::RX_IDLE; // see [R4]

    // ****************************************
    // assertions
    // ****************************************
    property p_wake_flag;
        wake_evt |=> rx_flag_reg;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake event did not set receive flag"); // see [R2]

    property p_wake_clear;
        wake_end && !wr_ctrl |=> !ctrl_reg.wake_on_break_enable;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake enable not cleared on rise"); // see [R2]

    property p_wake_idle;
        ctrl_reg.wake_on_break_enable |=> rx_state_reg == slbs_pkg::RX_IDLE;
    endproperty
    a_wake_idle: assert property (p_wake_idle) else $error("receiver ran while wake enabled"); // see [R1]

    property p_read_clear;
        rd_rx && !rx_done && !wake_evt |=> !rx_flag_reg;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("receive data read left flag set"); // see [R3]

    property p_break_zero;
        tx_busy_reg && tx_break_reg && tx_left_reg > 4'h1 |-> tx_bit == 1'b0;
    endproperty
    a_break_zero: assert property (p_break_zero) else $error("non-zero bit inside break"); // see [R7]

    property p_break_len;
        load && !ctrl_reg.sync_mode && ctrl_reg.send_break_request |=> tx_left_reg == 4'he;
    endproperty
    a_break_len: assert property (p_break_len) else $error("break frame length wrong"); // see [R5]

    property p_break_done;
        break_done && !wr_ctrl |=> !ctrl_reg.send_break_request && status.shift_register_empty_status;
    endproperty
    a_break_done: assert property (p_break_done) else $error("send-break not cleared at break end"); // see [R8]

    property p_tx_flag;
        wr_tx |=> !status.transmit_interrupt_flag;
    endproperty
    a_tx_flag: assert property (p_tx_flag) else $error("transmit flag set after data write"); // see [R11]

    property p_rx_break;
        rx_done && !rx_now && rx_shift_reg == 8'h00 |=> rx_flag_reg && framing_error_flag_reg && rx_data_reg == 8'h00;
    endproperty
    a_rx_break: assert property (p_rx_break) else $error("received break not flagged"); // see [R12]

    property p_sync_len;
        load && ctrl_reg.sync_mode |=> tx_left_reg == 4'h8;
    endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync character length wrong"); // see [R18]

    property p_clk_idle;
        sync_master && !tx_busy_reg ##1 sync_master |-> clk_pin_out == $past(ctrl_reg.clock_polarity_select);
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("sync clock not at idle level"); // see [R20]

    property p_clk_oe;
        sync_master |=> clk_pin_oe;
    endproperty
    a_clk_oe: assert property (p_clk_oe) else $error("clock pin driver not enabled"); // see [R17]

    c_break_sent: cover property (break_done);
    c_wake: cover property (wake_evt ##[1:1000] wake_end);
    c_sync_char: cover property (load && ctrl_reg.sync_mode);
    c_rx_break: cover property (rx_done && !rx_now);

endmodule

// File: core/slbs_pkg.sv
package slbs_pkg;

    // ****************************************
    // register map, word addresses
    // ****************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TXDATA = 4'h1;
    localparam logic [3:0] ADDR_RXDATA = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_BAUD = 4'h4;

    // ****************************************
    // field layouts and reset values
    // ****************************************
    typedef struct packed {
        logic auto_baud_enable;
        logic wake_on_break_enable;
        logic data_polarity_select;
        logic clock_polarity_select;
        logic continuous_receive_enable;
        logic single_receive_enable;
        logic master_clock_source_select;
        logic sync_mode;
        logic send_break_request;
        logic transmit_enable;
        logic serial_port_enable;
    } slbs_ctrl_t;

    typedef struct packed {
        logic receiver_idle_status;
        logic framing_error_flag;
        logic receive_interrupt_flag;
        logic transmit_interrupt_flag;
        logic shift_register_empty_status;
    } slbs_status_t;

    typedef struct packed {
        logic out;
        logic oe;
    } slbs_pin_t;

    localparam int CTRL_W = 11;
    localparam int STATUS_W = 5;
    localparam slbs_ctrl_t CTRL_RESET = 11'h000;
    localparam logic [15:0] BAUD_RESET = 16'h0010;

    // ****************************************
    // character framing
    // ****************************************
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] BREAK_ZERO_BITS = 4'hc;
    localparam logic [3:0] ASYNC_FRAME_BITS = DATA_BITS + 4'h2;
    localparam logic [3:0] BREAK_FRAME_BITS = BREAK_ZERO_BITS + 4'h2;

    // ****************************************
    // receiver states
    // ****************************************
    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP,
        RX_HOLD
    } slbs_rx_state_t;

endpackage

// File: verif/slbs_line_model.sv
`timescale 1ns/1ps

// ****************************************
// line partner: lin node and sync slave
// ****************************************
module slbs_line_model (
    // system clock
    input wire logic clock,
    // pins of the port
    input wire logic data_pin_out,
    input wire logic data_pin_oe,
    input wire logic clk_pin_out,
    input wire logic clk_pin_oe,
    output logic data_pin_in,
    // sync clock polarity in use
    input wire logic pol
);
    logic drive = 1'b1;
    logic tx_line;
    logic clk_q = 1'b0;
    logic [9:0] frame;
    logic [9:0] frames[$];
    logic [15:0] sbits = 16'h0000;
    int scount = 0;
    int run = 0;
    int max_run = 0;

    // model drives the data line while released; pull-up on the clock line
    assign data_pin_in = data_pin_oe ? data_pin_out : drive;
    assign tx_line = clk_pin_oe ? clk_pin_out : 1'b1;

    // bits lsb first, eight clocks each, then idle high
    task automatic send_bits(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            drive <= v[i];
            repeat (8) @(posedge clock);
        end
        drive <= 1'b1;
    endtask

    // async frames sampled mid-bit
    initial begin
        forever begin
            @(negedge tx_line);
            repeat (4) @(posedge clock);
            for (int i = 0; i < 10; i++) begin
                frame[i] = tx_line;
                repeat (8) @(posedge clock);
            end
            frames.push_back(frame);
            wait (tx_line);
        end
    end

    // low run length and sync sampling edge
    always @(posedge clock) begin
        clk_q <= clk_pin_out;
        run <= tx_line ? 0 : run + 1;
        if (run > max_run) begin
            max_run <= run;
        end
        if (clk_pin_oe && clk_q != clk_pin_out && clk_pin_out == pol) begin
            sbits <= {data_pin_out, sbits[15:1]};
            scount <= scount + 1;
        end
    end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    typedef struct {logic [3:0] a; logic [15:0] w; logic [15:0] r;} slbs_row_t;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic data_pin_in, data_pin_out, data_pin_oe, clk_pin_out, clk_pin_oe;
    logic clk_pin_in = 1'b0;
    logic pol = 1'b0;
    logic [15:0] d;
    int mismatches = 0;
    int num_checks = 0;
    slbs_row_t rows[5] = '{'{slbs_pkg::ADDR_BAUD, 16'h0001, 16'h0002}, '{4'hf, 16'hffff, 16'h0000},
        '{slbs_pkg::ADDR_CTRL, 16'h0400, 16'h0400}, '{slbs_pkg::ADDR_CTRL, 16'h0000, 16'h0000},
        '{slbs_pkg::ADDR_BAUD, 16'h0008, 16'h0008}};

    always #5 clock = ~clock;
    always #40 clk_pin_in = ~clk_pin_in;

    slbs_serial_port dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .data_pin_in(data_pin_in),
        .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .clk_pin_in(clk_pin_in),
        .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe));
    slbs_line_model peer (.clock(clock), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
        .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe), .data_pin_in(data_pin_in), .pol(pol));

    // ****************************************
    // bus and check tasks
    // ****************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] w);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= w;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rchk(input string name, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
        check(name, d & m, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        cyc(2);
        reset <= 1'b0;
        rchk("ctrl reset", slbs_pkg::ADDR_CTRL, 16'hffff, 16'h0000);
        rchk("baud reset", slbs_pkg::ADDR_BAUD, 16'hffff, 16'h0010);
        rchk("status reset", slbs_pkg::ADDR_STATUS, 16'h000f, 16'h0003);
        check("pin oe reset", {14'h0, clk_pin_oe, data_pin_oe}, 16'h0000);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rchk("register row", rows[i].a, 16'hffff, rows[i].r);
        end
        $display("test registers done");
        wr(slbs_pkg::ADDR_CTRL, 16'h0003);
        peer.frames.delete();
        wr(slbs_pkg::ADDR_TXDATA, 16'h00a5);
        cyc(100);
        check("async frame", {6'h0, peer.frames[0]}, 16'h034a);
        $display("test async transmit done");
        wr(slbs_pkg::ADDR_CTRL, 16'h0007);
        cyc(20);
        rchk("no break yet", slbs_pkg::ADDR_STATUS, 16'h0001, 16'h0001);
        peer.frames.delete();
        peer.max_run = 0;
        wr(slbs_pkg::ADDR_TXDATA, 16'h00ff);
        cyc(3);
        rchk("holding empty", slbs_pkg::ADDR_STATUS, 16'h0002, 16'h0002);
        wr(slbs_pkg::ADDR_TXDATA, 16'h0055);
        rchk("break busy", slbs_pkg::ADDR_STATUS, 16'h0003, 16'h0000);
        cyc(120);
        rchk("send break cleared", slbs_pkg::ADDR_CTRL, 16'hffff, 16'h0003);
        cyc(100);
        check("break frame", {6'h0, peer.frames[0]}, 16'h0000);
        check("break low run", peer.max_run[15:0], 16'd104);
        check("sync byte", {6'h0, peer.frames[1]}, 16'h02aa);
        $display("test break done");
        rchk("receiver idle", slbs_pkg::ADDR_STATUS, 16'h0010, 16'h0010);
        wr(slbs_pkg::ADDR_CTRL, 16'h0241);
        peer.send_bits(16'h0000, 13);
        rchk("wake flag", slbs_pkg::ADDR_STATUS, 16'h000c, 16'h0004);
        cyc(10);
        rchk("wake cleared", slbs_pkg::ADDR_CTRL, 16'hffff, 16'h0041);
        rchk("discard read", slbs_pkg::ADDR_RXDATA, 16'hffff, 16'h0000);
        rchk("wake flag cleared", slbs_pkg::ADDR_STATUS, 16'h0004, 16'h0000);
        peer.send_bits({6'h0, 1'b1, 8'h5a, 1'b0}, 10);
        cyc(20);
        rchk("byte flag", slbs_pkg::ADDR_STATUS, 16'h000c, 16'h0004);
        rchk("byte data", slbs_pkg::ADDR_RXDATA, 16'hffff, 16'h005a);
        peer.send_bits(16'h0000, 13);
        cyc(20);
        rchk("break flags", slbs_pkg::ADDR_STATUS, 16'h000c, 16'h000c);
        rchk("break data", slbs_pkg::ADDR_RXDATA, 16'hffff, 16'h0000);
        $display("test receive done");
        for (int k = 0; k < 2; k++) begin
            pol <= (k == 0);
            wr(slbs_pkg::ADDR_CTRL, k == 0 ? 16'h009b : 16'h011b);
            cyc(4);
            #1;
            check("clock idle", {14'h0, clk_pin_oe, clk_pin_out}, {15'h0001, k == 0});
            peer.scount = 0;
            wr(slbs_pkg::ADDR_TXDATA, 16'h003c);
            wr(slbs_pkg::ADDR_TXDATA, 16'h00c3);
            cyc(2);
            #1;
            check("sync drivers", {14'h0, clk_pin_oe, data_pin_oe}, 16'h0003);
            cyc(200);
            check("sync clock count", peer.scount[15:0], 16'd16);
            check("sync data", peer.sbits, k == 0 ? 16'hc33c : 16'h3cc3);
        end
        wr(slbs_pkg::ADDR_CTRL, 16'h003b);
        cyc(3);
        #1;
        check("receive mode", {15'h0, data_pin_oe}, 16'h0000);
        $display("test sync master done");
        complete_run();
    end

    initial begin
        cyc(20000);
        mismatches++;
        complete_run();
    end
endmodule
